// ---- core/shd_core.v ----
/*
 safe homing logic, direct mode, with register port, interrupt and fail-safe handling.
 assumes homing_request, ref_switch_input and encoder status come from pins;
 position and speed come from same-clock logic; one clock mclk at 20 MHz.
*/
// What this block does
// - in direct mode a request rising edge loads home value into actual position
// - direct mode never looks at the reference switch input
// - speed or position beyond standstill tolerance during request gives functional error
// - any error during homing with the request still held enters the acknowledgeable functional fail-safe state
// - functional fail-safe drops func_error_free and removes drive torque
// - safe_pos_ok only while referenced, cleared at once on any encoder error
// - direct mode with reference pulse fails the startup configuration check
// - with max position monitoring, home value must sit inside the limits
// - configuration fail-safe only leaves by power cycle, never by acknowledge
// - mode field codes direct, reference switch, home offset, offset with correction; only direct is built
// - home value, limits, tolerances default zero; monitoring and pulse default off
// - request edge starts homing and clears homed_pos_ok; completion sets it
// - homing ends in its first cycle, before the monitoring timer flag can rise
// - request dropped before completion aborts the homing
`timescale 1ns/1ps
`default_nettype none
`include "shd_regs.vh"
module shd_core (
	// clock and reset
	input wire mclk,
	input wire rstn,
	input wire clk_en,
	// register port
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata_ff,
	// pins from the safe application and encoder
	input wire homing_request,
	input wire ref_switch_input,
	input wire enc_error,
	// axis feedback on mclk
	input wire [31:0] enc_pos,
	input wire [31:0] enc_speed,
	// outputs
	output reg homed_pos_ok_ff,
	output reg safe_pos_ok_ff,
	output reg func_error_free_ff,
	output reg torque_enable_ff,
	output reg cfg_failsafe_ff,
	output reg [31:0] act_pos_ff,
	output reg irq_ff
);
	// ==========================================================
	// states
	localparam ST_CHECK = 5'b00001;
	localparam ST_IDLE = 5'b00010;
	localparam ST_HOMING = 5'b00100;
	localparam ST_FERR = 5'b01000;
	localparam ST_CFGERR = 5'b10000;

	reg [4:0] state_ff;
	reg [4:0] nxt_state;
	reg [31:0] ctrl_ff;
	reg [31:0] home_ff;
	reg [31:0] lolim_ff;
	reg [31:0] hilim_ff;
	reg [31:0] spdtol_ff;
	reg [31:0] postol_ff;
	reg [31:0] montime_ff;
	reg [4:0] irq_stat_ff;
	reg [4:0] irq_en_ff;
	reg req_prev_ff;
	reg referenced_ff;
	reg [31:0] pos_offs_ff;
	reg ack_ff;
	reg [4:0] nxt_events;
	wire [2:0] pin_sync;
	wire req_s;
	wire refsw_s;
	wire enc_err_s;
	wire tmr_expired;
	wire req_rise;
	wire standstill_bad;
	wire cfg_bad;
	wire [1:0] mode;
	wire [31:0] home_pos_now;

	// ==========================================================
	// pin synchronisers
	shd_sync2 #(.W(3)) u_sync (
		.mclk(mclk),
		.rstn(rstn),
		.clk_en(clk_en),
		.d_in({enc_error, ref_switch_input, homing_request}),
		.q_ff(pin_sync)
	);
	assign req_s = pin_sync[0];
	// direct mode never uses the switch; kept synchronised for the status register
	assign refsw_s = pin_sync[1];
	assign enc_err_s = pin_sync[2];

	// ==========================================================
	// monitoring timer
	shd_tmr u_tmr (
		.mclk(mclk),
		.rstn(rstn),
		.clk_en(clk_en),
		.run(state_ff == ST_HOMING),
		.limit({8'h00, montime_ff} * 40'd`SHD_CLK_MHZ),
		.expired_ff(tmr_expired)
	);

	// ==========================================================
	// helpers
	function abs_over;
		input [31:0] v;
		input [31:0] tol;
		reg [31:0] mag;
		begin
			mag = v[31] ? (32'h0 - v) : v;
			abs_over = (mag > tol);
		end
	endfunction

	assign mode = ctrl_ff[`SHD_C_MODE_HI:`SHD_C_MODE_LO];
	assign req_rise = req_s & ~req_prev_ff;
	assign home_pos_now = enc_pos + pos_offs_ff;
	// standstill: speed and drift from the position at the request edge
	assign standstill_bad = abs_over(enc_speed, spdtol_ff) |
		abs_over(home_pos_now - act_pos_ff, postol_ff);
	assign cfg_bad = ((mode == `SHD_MODE_DIRECT) & ctrl_ff[`SHD_C_REFPULSE]) |
		(ctrl_ff[`SHD_C_MAXPOS] & (($signed(home_ff) < $signed(lolim_ff)) |
		($signed(home_ff) > $signed(hilim_ff))));

	// ==========================================================
	// state machine
	always @* begin
		nxt_state = state_ff;
		nxt_events = 5'h0;
		case (state_ff)
			ST_CHECK: begin
				// check runs once software sets the start bit after configuring
				if (ctrl_ff[`SHD_C_START]) begin
					if (cfg_bad || enc_err_s) begin
						nxt_state = ST_CFGERR;
						nxt_events[`SHD_E_CFGERR] = 1'b1;
					end else begin
						nxt_state = ST_IDLE;
					end
				end
			end
			ST_IDLE: begin
				// only direct mode is built; other modes refuse the request
				if (req_rise && mode == `SHD_MODE_DIRECT)
					nxt_state = ST_HOMING;
			end
			ST_HOMING: begin
				if (!req_s) begin
					nxt_state = ST_IDLE;
					nxt_events[`SHD_E_ABORT] = 1'b1;
				end else if (enc_err_s || standstill_bad || tmr_expired) begin
					nxt_state = ST_FERR;
					nxt_events[`SHD_E_FUNCERR] = 1'b1;
				end else begin
					nxt_state = ST_IDLE;
					nxt_events[`SHD_E_DONE] = 1'b1;
				end
			end
			ST_FERR: begin
				if (ack_ff && !enc_err_s)
					nxt_state = ST_IDLE;
			end
			ST_CFGERR: begin
				nxt_state = ST_CFGERR;
			end
			default: begin
				nxt_state = ST_CFGERR;
			end
		endcase
		if (enc_err_s && !irq_stat_ff[`SHD_E_ENCERR])
			nxt_events[`SHD_E_ENCERR] = 1'b1;
	end

	// ==========================================================
	// registers and datapath
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= ST_CHECK;
			ctrl_ff <= `SHD_RST_CTRL;
			home_ff <= `SHD_RST_VALUE;
			lolim_ff <= `SHD_RST_VALUE;
			hilim_ff <= `SHD_RST_VALUE;
			spdtol_ff <= `SHD_RST_VALUE;
			postol_ff <= `SHD_RST_VALUE;
			montime_ff <= `SHD_RST_VALUE;
			irq_stat_ff <= 5'h0;
			irq_en_ff <= 5'h0;
			req_prev_ff <= 1'b0;
			referenced_ff <= 1'b0;
			pos_offs_ff <= 32'h0;
			ack_ff <= 1'b0;
			homed_pos_ok_ff <= 1'b0;
			safe_pos_ok_ff <= 1'b0;
			func_error_free_ff <= 1'b0;
			torque_enable_ff <= 1'b0;
			cfg_failsafe_ff <= 1'b0;
			act_pos_ff <= 32'h0;
			irq_ff <= 1'b0;
			reg_rdata_ff <= 32'h0;
		end else if (clk_en) begin
			state_ff <= nxt_state;
			req_prev_ff <= req_s;
			ack_ff <= 1'b0;
			// configuration locks once the startup check has passed
			if (reg_wr && state_ff == ST_CHECK) begin
				case (reg_addr)
					`SHD_A_CTRL: ctrl_ff <= reg_wdata;
					`SHD_A_HOME: home_ff <= reg_wdata;
					`SHD_A_LOLIM: lolim_ff <= reg_wdata;
					`SHD_A_HILIM: hilim_ff <= reg_wdata;
					`SHD_A_SPDTOL: spdtol_ff <= reg_wdata;
					`SHD_A_POSTOL: postol_ff <= reg_wdata;
					`SHD_A_MONTIME: montime_ff <= reg_wdata;
					default: ;
				endcase
			end
			if (reg_wr && reg_addr == `SHD_A_CTRL)
				ack_ff <= reg_wdata[`SHD_C_ACK];
			if (reg_wr && reg_addr == `SHD_A_IRQEN)
				irq_en_ff <= reg_wdata[4:0];
			// set wins over clear
			if (reg_wr && reg_addr == `SHD_A_IRQCLR)
				irq_stat_ff <= (irq_stat_ff & ~reg_wdata[4:0]) | nxt_events;
			else
				irq_stat_ff <= irq_stat_ff | nxt_events;
			irq_ff <= |((irq_stat_ff | nxt_events) & irq_en_ff);
			// actual position: encoder plus offset captured at homing
			if (state_ff == ST_IDLE && nxt_state == ST_HOMING) begin
				pos_offs_ff <= home_ff - enc_pos;
				act_pos_ff <= home_ff;
			end else begin
				act_pos_ff <= home_pos_now;
			end
			if (state_ff == ST_IDLE && nxt_state == ST_HOMING)
				referenced_ff <= 1'b0;
			else if (nxt_events[`SHD_E_DONE])
				referenced_ff <= 1'b1;
			else if (enc_err_s || nxt_state == ST_CFGERR)
				referenced_ff <= 1'b0;
			homed_pos_ok_ff <= (referenced_ff | nxt_events[`SHD_E_DONE]) &
				~(state_ff == ST_IDLE && nxt_state == ST_HOMING) & ~enc_err_s;
			// cleared on the first synchronised encoder error, however short
			safe_pos_ok_ff <= referenced_ff & ~enc_err_s &
				~(state_ff == ST_IDLE && nxt_state == ST_HOMING);
			func_error_free_ff <= ~nxt_state[3] & ~nxt_state[4] & ~nxt_state[0];
			torque_enable_ff <= ~nxt_state[3] & ~nxt_state[4] & ~nxt_state[0];
			cfg_failsafe_ff <= nxt_state[4];
			if (reg_rd) begin
				case (reg_addr)
					`SHD_A_CTRL: reg_rdata_ff <= ctrl_ff;
					`SHD_A_HOME: reg_rdata_ff <= home_ff;
					`SHD_A_LOLIM: reg_rdata_ff <= lolim_ff;
					`SHD_A_HILIM: reg_rdata_ff <= hilim_ff;
					`SHD_A_SPDTOL: reg_rdata_ff <= spdtol_ff;
					`SHD_A_POSTOL: reg_rdata_ff <= postol_ff;
					`SHD_A_MONTIME: reg_rdata_ff <= montime_ff;
					`SHD_A_STATUS: reg_rdata_ff <= {24'h0, refsw_s, referenced_ff, 1'b0, state_ff};
					`SHD_A_ACTPOS: reg_rdata_ff <= act_pos_ff;
					`SHD_A_IRQSTAT: reg_rdata_ff <= {27'h0, irq_stat_ff};
					`SHD_A_IRQEN: reg_rdata_ff <= {27'h0, irq_en_ff};
					default: reg_rdata_ff <= 32'h0;
				endcase
			end else begin
				reg_rdata_ff <= 32'h0;
			end
		end
	end
endmodule
`default_nettype wire

// ---- core/shd_regs.vh ----
/*
 safe homing, direct mode: register offsets, field positions, reset values and timing counts.
 assumes the includer runs on mclk at 20 MHz with an 8-bit register port and 32-bit data.
*/
`ifndef SHD_REGS_VH
`define SHD_REGS_VH
// ==========================================================
// register offsets (byte addresses, one word each)
`define SHD_A_CTRL 8'h00
`define SHD_A_HOME 8'h04
`define SHD_A_LOLIM 8'h08
`define SHD_A_HILIM 8'h0c
`define SHD_A_SPDTOL 8'h10
`define SHD_A_POSTOL 8'h14
`define SHD_A_MONTIME 8'h18
`define SHD_A_STATUS 8'h1c
`define SHD_A_ACTPOS 8'h20
`define SHD_A_IRQSTAT 8'h24
`define SHD_A_IRQCLR 8'h28
`define SHD_A_IRQEN 8'h2c
// ==========================================================
// control register fields
`define SHD_C_MODE_LO 0
`define SHD_C_MODE_HI 1
`define SHD_C_REFPULSE 2
`define SHD_C_MAXPOS 3
`define SHD_C_START 4
`define SHD_C_ACK 5
// ==========================================================
// homing modes
`define SHD_MODE_DIRECT 2'h0
`define SHD_MODE_REFSW 2'h1
`define SHD_MODE_OFFS 2'h2
`define SHD_MODE_OFFSCOR 2'h3
// ==========================================================
// reset values
`define SHD_RST_CTRL 32'h00000000
`define SHD_RST_VALUE 32'h00000000
// ==========================================================
// interrupt event bits
`define SHD_E_DONE 0
`define SHD_E_FUNCERR 1
`define SHD_E_CFGERR 2
`define SHD_E_ENCERR 3
`define SHD_E_ABORT 4
// ==========================================================
// timing: monitoring time in microseconds, cycles per microsecond at 20 MHz
`define SHD_CLK_MHZ 20
`define SHD_US_TO_CYC(us) ((us) * `SHD_CLK_MHZ)
`endif

// ---- core/shd_sync2.v ----
/*
 two-flip-flop synchroniser for a vector of pin inputs.
 assumes the inputs change asynchronously to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module shd_sync2 #(
	parameter W = 1
) (
	// clock and reset
	input wire mclk,
	input wire rstn,
	input wire clk_en,
	// data
	input wire [W-1:0] d_in,
	output reg [W-1:0] q_ff
);
	reg [W-1:0] meta_ff;

	// ==========================================================
	// first stage feeds only the second
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			meta_ff <= {W{1'b0}};
			q_ff <= {W{1'b0}};
		end else if (clk_en) begin
			meta_ff <= d_in;
			q_ff <= meta_ff;
		end
	end
endmodule
`default_nettype wire

// ---- core/shd_tmr.v ----
/*
 homing monitoring timer: counts cycles while running, flags expiry.
 assumes a limit in cycles from the main block; a zero limit expires after the first running cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module shd_tmr (
	// clock and reset
	input wire mclk,
	input wire rstn,
	input wire clk_en,
	// control
	input wire run,
	input wire [39:0] limit,
	// status
	output reg expired_ff
);
	reg [39:0] cnt_ff;

	// ==========================================================
	// counter clears whenever not running
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt_ff <= 40'h0;
			expired_ff <= 1'b0;
		end else if (clk_en) begin
			if (!run) begin
				cnt_ff <= 40'h0;
				expired_ff <= 1'b0;
			end else begin
				if (cnt_ff < limit)
					cnt_ff <= cnt_ff + 40'h1;
				expired_ff <= (cnt_ff >= limit);
			end
		end
	end
endmodule
`default_nettype wire

// ---- verif/shd_axis.sv ----
/*
 safe application and axis model.
 assumes bench commands change off the clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module shd_axis (
	// clock
	input wire logic mclk,
	// bench commands
	input wire logic req,
	input wire logic err,
	input wire logic [31:0] spd,
	// toward the block
	output logic homing_request,
	output logic ref_switch_input,
	output logic enc_error,
	output logic [31:0] enc_pos,
	output logic [31:0] enc_speed
);
	initial begin
		homing_request = 1'h0;
		ref_switch_input = 1'h0;
		enc_error = 1'h0;
		enc_pos = 32'h00000777;
		enc_speed = 32'h0;
	end
	// axis parked; speed only breaks standstill when told
	always @(posedge mclk) begin
		homing_request <= req;
		enc_pos <= 32'h00000777;
		enc_speed <= spd;
		enc_error <= err;
		// switch toggles so any use of it shows
		ref_switch_input <= ~ref_switch_input;
	end
endmodule
`default_nettype wire

// ---- verif/shd_chk.sv ----
/*
 checker on the shd_core ports.
 assumes clk_en held high; bound to every shd_core.
*/
`timescale 1ns/1ps
`default_nettype none
module shd_chk (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// watched
	input wire logic homing_request,
	input wire logic enc_error,
	input wire logic homed_pos_ok_ff,
	input wire logic safe_pos_ok_ff,
	input wire logic func_error_free_ff,
	input wire logic torque_enable_ff,
	input wire logic cfg_failsafe_ff
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	// ==========================================
	// fail-safe
	property p_trq; func_error_free_ff == torque_enable_ff; endproperty
	a_trq: assert property (p_trq) else $error("torque differs");
	property p_stick; cfg_failsafe_ff |=> cfg_failsafe_ff; endproperty
	a_stick: assert property (p_stick) else $error("cfg left");
	property p_cfg; cfg_failsafe_ff |-> !func_error_free_ff; endproperty
	a_cfg: assert property (p_cfg) else $error("cfg yet free");
	property p_ctq; cfg_failsafe_ff |-> !torque_enable_ff; endproperty
	a_ctq: assert property (p_ctq) else $error("cfg yet torque");
	property p_ack; $rose(func_error_free_ff) |-> !$past(cfg_failsafe_ff); endproperty
	a_ack: assert property (p_ack) else $error("free from cfg");
	// ==========================================
	// position
	// pins pass a two-stage sync, hence five cycles
	property p_enc; enc_error [*5] |-> !safe_pos_ok_ff && !homed_pos_ok_ff; endproperty
	a_enc: assert property (p_enc) else $error("pos ok on enc err");
	property p_done; $rose(homed_pos_ok_ff) |-> $past(homing_request, 3); endproperty
	a_done: assert property (p_done) else $error("done w/o request");
	property p_safe; $rose(homed_pos_ok_ff) |-> ##[0:1] safe_pos_ok_ff; endproperty
	a_safe: assert property (p_safe) else $error("safe ok late");
endmodule
bind shd_core shd_chk u_chk (.mclk(mclk), .rstn(rstn), .homing_request(homing_request),
	.enc_error(enc_error), .homed_pos_ok_ff(homed_pos_ok_ff), .safe_pos_ok_ff(safe_pos_ok_ff),
	.func_error_free_ff(func_error_free_ff), .torque_enable_ff(torque_enable_ff),
	.cfg_failsafe_ff(cfg_failsafe_ff));
`default_nettype wire

// ---- verif/tb_top.sv ----
/*
 testbench for shd_core.
 assumes shd_regs.vh on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "shd_regs.vh"
module tb_top;
	logic mclk = 0, rstn = 0, wr = 0, rd = 0, req = 0, err = 0;
	logic [7:0] addr = 0;
	logic [31:0] wd = 0, spd = 0, rdv;
	wire hr, rs, ee, hp, sp, fe, te, cf, irq;
	wire [31:0] rdata, ep, es, ap;
	int failures = 0, tests_run = 0;
	always #25 mclk = ~mclk;
	shd_axis axis (.mclk(mclk), .req(req), .err(err), .spd(spd), .homing_request(hr),
		.ref_switch_input(rs), .enc_error(ee), .enc_pos(ep), .enc_speed(es));
	shd_core dut (.mclk(mclk), .rstn(rstn), .clk_en(1'h1), .reg_addr(addr), .reg_wdata(wd),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata_ff(rdata), .homing_request(hr),
		.ref_switch_input(rs), .enc_error(ee), .enc_pos(ep), .enc_speed(es),
		.homed_pos_ok_ff(hp), .safe_pos_ok_ff(sp), .func_error_free_ff(fe),
		.torque_enable_ff(te), .cfg_failsafe_ff(cf), .act_pos_ff(ap), .irq_ff(irq));
	// ==========================================
	// helpers
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wd <= d;
		wr <= 1'h1;
		@(posedge mclk);
		wr <= 1'h0;
	endtask
	task rreg(input logic [7:0] a);
		@(posedge mclk);
		addr <= a;
		rd <= 1'h1;
		@(posedge mclk);
		rd <= 1'h0;
		#1 rdv = rdata;
	endtask
	task do_reset;
		@(posedge mclk);
		rstn <= 1'h0;
		repeat (16) @(posedge mclk);
		rstn <= 1'h1;
	endtask
	task home(input logic [31:0] s);
		spd <= s;
		req <= 1'h1;
		cyc(8);
	endtask
	// ==========================================
	// scenarios
	task t_defaults;
		for (int a = 0; a <= 8'h18; a += 4) begin
			rreg(a[7:0]);
			chk(rdv, 32'h0);
		end
		rreg(8'h30);
		chk(rdv, 32'h0);
		$display("t_defaults done");
	endtask
	task t_direct;
		wreg(`SHD_A_HOME, 32'h1234);
		wreg(`SHD_A_SPDTOL, 32'h10);
		wreg(`SHD_A_POSTOL, 32'h10);
		wreg(`SHD_A_MONTIME, 32'h64);
		wreg(`SHD_A_IRQEN, 32'h1f);
		wreg(`SHD_A_CTRL, 32'h10);
		cyc(3);
		chk(fe, 1'h1);
		home(32'h0);
		chk(hp, 1'h1);
		chk(sp, 1'h1);
		chk(ap, 32'h1234);
		chk(irq, 1'h1);
		rreg(`SHD_A_IRQSTAT);
		chk(rdv[0], 1'h1);
		wreg(`SHD_A_IRQCLR, 32'h1f);
		cyc(1);
		chk(irq, 1'h0);
		req <= 1'h0;
		$display("t_direct done");
	endtask
	task t_still;
		cyc(4);
		home(32'h100);
		chk(fe, 1'h0);
		chk(te, 1'h0);
		chk(hp, 1'h0);
		req <= 1'h0;
		spd <= 32'h0;
		wreg(`SHD_A_CTRL, 32'h20);
		cyc(2);
		chk(fe, 1'h1);
		$display("t_still done");
	endtask
	task t_enc;
		home(32'h0);
		chk(sp, 1'h1);
		err <= 1'h1;
		cyc(6);
		err <= 1'h0;
		chk(sp, 1'h0);
		req <= 1'h0;
		$display("t_enc done");
	endtask
	task t_abort;
		@(posedge mclk);
		req <= 1'h1;
		@(posedge mclk);
		req <= 1'h0;
		cyc(8);
		chk(hp, 1'h0);
		rreg(`SHD_A_IRQSTAT);
		chk(rdv[4], 1'h1);
		$display("t_abort done");
	endtask
	task t_modes;
		for (int m = 1; m < 4; m++) begin
			do_reset();
			wreg(`SHD_A_CTRL, 32'h10 | m);
			cyc(3);
			home(32'h0);
			chk(hp, 1'h0);
			req <= 1'h0;
		end
		$display("t_modes done");
	endtask
	task t_cfg;
		do_reset();
		wreg(`SHD_A_CTRL, 32'h14);
		cyc(3);
		chk(cf, 1'h1);
		wreg(`SHD_A_CTRL, 32'h20);
		cyc(2);
		chk(cf, 1'h1);
		do_reset();
		wreg(`SHD_A_LOLIM, 32'h10);
		wreg(`SHD_A_HILIM, 32'h20);
		wreg(`SHD_A_HOME, 32'h30);
		wreg(`SHD_A_CTRL, 32'h18);
		cyc(3);
		chk(cf, 1'h1);
		$display("t_cfg done");
	endtask
	task print_verdict;
		$display("comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		do_reset();
		t_defaults();
		t_direct();
		t_still();
		t_enc();
		t_abort();
		t_modes();
		t_cfg();
		print_verdict();
	end
endmodule
`default_nettype wire
